// file: src/wdt_defines.vh
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Clock and watchdog oscillator timing
`define CLK_PERIOD_NS       10
`define RC_OSC_PERIOD_NS    80
`define RC_OSC_DIV          ((`RC_OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register indices; byte address is four times the index
`define IDX_STATUS          14'h0003
`define IDX_IRQ_STAT        14'h0004
`define IDX_IRQ_MASK        14'h0005
`define IDX_OPTION          14'h0081
`define IDX_CONFIG          14'h2007

// Decoded register selects
`define SEL_NONE            3'h0
`define SEL_STATUS          3'h1
`define SEL_IRQ_STAT        3'h2
`define SEL_IRQ_MASK        3'h3
`define SEL_OPTION          3'h4
`define SEL_CONFIG          3'h5

// Option register fields
`define OPT_PSA_BIT         3
`define OPT_PS_HI           2
`define OPT_PS_LO           0
`define OPTION_RESET        8'hff

// Configuration word fields
`define CFG_WATCHDOG_ENABLE_FUSE_BIT        2
`define CONFIG_RESET        14'h3fff

// Status register fields
`define ST_PD_BIT           0
`define ST_TO_BIT           1
`define ST_SLEEP_BIT        2
`define ST_EN_BIT           3
`define FLAG_RESET          1'b1

// Interrupt status bits
`define IRQ_RESET_BIT       0
`define IRQ_WAKE_BIT        1

// Watchdog count
`define WDT_CNT_W           8
`define WDT_CNT_MAX         8'hff
`define WDT_CNT_ZERO        8'h00

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: src/wdt_rc_osc.v
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the dedicated watchdog oscillator: a tick every DIV cycles.
// It is never gated by sleep, so the count keeps advancing while the core is halted.
module wdt_rc_osc #(
   parameter DIV = 8
) (
   input  wire       aclk,
   input  wire       aresetn,
   output reg        tick_q
);

   reg  [15:0]       div_q;
   localparam [31:0] DIV_M1   = DIV - 1;
   localparam [15:0] DIV_LAST = DIV_M1[15:0];

   // Free-running divider
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q == DIV_LAST) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

endmodule // wdt_rc_osc

`default_nettype wire

// file: src/wdt_postscaler.v
`timescale 1ns/1ps
`default_nettype none

// Shared prescaler used as a divide-by-2^n postscaler on the watchdog
module wdt_postscaler #(
   parameter W = 8
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire         clear,
   input  wire         step,
   input  wire [2:0]   ratio,
   output wire         wrap
);

   reg  [W-1:0]        cnt_q;
   wire [W-1:0]        mask;

   // Ratio n gives mask 2^n-1; n=0 wraps on every step
   function [W-1:0] ratio_mask;
      input [2:0] r;
      begin
         ratio_mask = ({{(W-1){1'b0}}, 1'b1} << r) - {{(W-1){1'b0}}, 1'b1};
      end
   endfunction

   assign mask = ratio_mask(ratio);
   assign wrap = step && ((cnt_q & mask) == mask); // [R11]

   // Clear beats a step in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= {W{1'b0}};
      end else if (clear) begin
         cnt_q <= {W{1'b0}}; // [R08]
      end else if (wrap) begin
         cnt_q <= {W{1'b0}};
      end else if (step) begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule // wdt_postscaler

`default_nettype wire

// file: src/wdt_top.v
// Function
// [R01] Watchdog counts ticks of its own oscillator, unaffected by the halted main clock.
// [R02] Expiry while running sends a watchdog reset request to the core.
// [R03] Expiry while sleeping wakes the core instead of resetting it.
// [R04] Every expiry drives the time-out status flag low.
// [R05] Configuration word enable bit low holds the watchdog permanently inactive.
// [R06] Shared prescaler, when assigned by the option register, postscales watchdog expiry.
// [R07] Clear or sleep instruction resets count and assigned postscaler, preventing expiry.
// [R08] Clear instruction zeroes prescaler count, leaves the assignment bit unchanged; a clear zeroes the count only while the prescaler is assigned.
// [R09] Sleep loads count and prescaler with zero, sets time-out, clears power-down.
// [R10] After sleep the main oscillator stops while the watchdog oscillator runs on.
// [R11] Base period is a build parameter; ratio selects postscale 1:1 to 1:128.
// [R12] Core gives clear and sleep pulses; watchdog returns reset and wake pulses.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"

module wdt_top #(
   parameter OSC_DIV = `RC_OSC_DIV,
   parameter [13:0] CONFIG_WORD = `CONFIG_RESET
) (
   input  wire         aclk,
   input  wire         aresetn,
   // AXI4-Lite write address
   input  wire [15:0]  s_axi_awaddr,
   input  wire         s_axi_awvalid,
   output reg          s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]  s_axi_wdata,
   input  wire [3:0]   s_axi_wstrb,
   input  wire         s_axi_wvalid,
   output reg          s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]   s_axi_bresp,
   output reg          s_axi_bvalid,
   input  wire         s_axi_bready,
   // AXI4-Lite read address
   input  wire [15:0]  s_axi_araddr,
   input  wire         s_axi_arvalid,
   output reg          s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]  s_axi_rdata,
   output reg  [1:0]   s_axi_rresp,
   output reg          s_axi_rvalid,
   input  wire         s_axi_rready,
   // Core side
   input  wire         watchdog_clear_instr,
   input  wire         sleep_instr,
   output reg          reset_req_q,
   output reg          wake_req_q,
   output reg          sleeping_q,
   output reg          main_osc_en_q,
   output reg          timeout_status_flag,
   output reg          powerdown_status_flag,
   output reg          irq_q
);

   // Write channel holding state
   reg                 aw_full_q;
   reg                 w_full_q;
   reg  [13:0]         aw_idx_q;
   reg  [31:0]         wdata_q;
   reg  [3:0]          wstrb_q;

   // Registers
   reg  [7:0]          timer_option_control_q;
   reg  [13:0]         config_q;
   reg  [1:0]          irq_stat_q;
   reg  [1:0]          irq_mask_q;

   // Watchdog state
   reg  [`WDT_CNT_W-1:0] watchdog_timer_q;

   // Internal
   wire                osc_tick;
   wire                post_wrap;
   wire                watchdog_enable_fuse;
   wire                prescaler_assign_select;
   wire [2:0]          prescale_ratio_select;
   wire                base_wrap;
   wire                clear_evt;
   wire                expire;
   wire                expire_reset;
   wire                expire_wake;
   wire                do_write;
   wire [2:0]          wr_sel;
   wire [2:0]          rd_sel;
   wire                wr_lane0;
   wire [1:0]          wr_resp;
   wire [31:0]         status_word;
   wire [1:0]          irq_clr;
   wire [1:0]          irq_set;
   wire [1:0]          irq_stat_d;

   // Map a word index to a register select
   function [2:0] reg_decode;
      input [13:0] idx;
      begin
         case (idx)
            `IDX_STATUS:   reg_decode = `SEL_STATUS;
            `IDX_IRQ_STAT: reg_decode = `SEL_IRQ_STAT;
            `IDX_IRQ_MASK: reg_decode = `SEL_IRQ_MASK;
            `IDX_OPTION:   reg_decode = `SEL_OPTION;
            `IDX_CONFIG:   reg_decode = `SEL_CONFIG;
            default:       reg_decode = `SEL_NONE;
         endcase
      end
   endfunction

   // Dedicated watchdog oscillator, never stopped by sleep
   wdt_rc_osc #(
      .DIV     (OSC_DIV)
   ) u_osc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick_q  (osc_tick)
   ); // [R01]

   // Option and configuration fields
   assign watchdog_enable_fuse    = config_q[`CFG_WATCHDOG_ENABLE_FUSE_BIT];
   assign prescaler_assign_select = timer_option_control_q[`OPT_PSA_BIT];
   assign prescale_ratio_select   = timer_option_control_q[`OPT_PS_HI:`OPT_PS_LO];

   // Base count wraps on the tick that leaves the top value
   assign base_wrap = watchdog_enable_fuse && osc_tick &&
                      (watchdog_timer_q == `WDT_CNT_MAX); // [R05]
   assign clear_evt = watchdog_clear_instr || sleep_instr; // [R12]

   // Postscaler steps on base wraps only while assigned to the watchdog
   wdt_postscaler #(
      .W       (8)
   ) u_post (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   ((watchdog_clear_instr && prescaler_assign_select) || sleep_instr), // [R07]
      .step    (base_wrap && prescaler_assign_select), // [R06]
      .ratio   (prescale_ratio_select),
      .wrap    (post_wrap)
   );

   // A clear in the same cycle suppresses the expiry
   assign expire       = base_wrap && (prescaler_assign_select ? post_wrap : 1'b1) &&
                         !clear_evt; // [R07]
   assign expire_reset = expire && !sleeping_q; // [R02]
   assign expire_wake  = expire && sleeping_q;  // [R03]

   // Watchdog count, held at zero while the fuse is off
   always @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_timer_q <= `WDT_CNT_ZERO;
      end else if (!watchdog_enable_fuse) begin
         watchdog_timer_q <= `WDT_CNT_ZERO; // [R05]
      end else if (clear_evt) begin
         watchdog_timer_q <= `WDT_CNT_ZERO; // [R07] [R09]
      end else if (osc_tick) begin
         watchdog_timer_q <= watchdog_timer_q + 8'h01; // [R01]
      end
   end

   // Power states; the state register doubles as the sleeping output
   localparam [0:0] PWR_RUN   = 1'b0;
   localparam [0:0] PWR_SLEEP = 1'b1;

   // One-cycle request pulses back to the core
   always @(posedge aclk) begin
      if (!aresetn) begin
         reset_req_q <= 1'b0;
         wake_req_q  <= 1'b0;
      end else begin
         reset_req_q <= expire_reset; // [R02] [R12]
         wake_req_q  <= expire_wake;  // [R03] [R12]
      end
   end

   // Run and sleep; only an expiry ends sleep, the watchdog keeps running
   always @(posedge aclk) begin
      if (!aresetn) begin
         sleeping_q    <= PWR_RUN;
         main_osc_en_q <= 1'b1;
      end else begin
         case (sleeping_q)
            PWR_RUN: begin
               if (sleep_instr) begin
                  sleeping_q    <= PWR_SLEEP; // [R10]
                  main_osc_en_q <= 1'b0;      // [R10]
               end
            end
            PWR_SLEEP: begin
               if (expire) begin
                  sleeping_q    <= PWR_RUN; // [R03]
                  main_osc_en_q <= 1'b1;    // [R03]
               end
            end
            default: begin
               sleeping_q    <= PWR_RUN;
               main_osc_en_q <= 1'b1;
            end
         endcase
      end
   end

   // Status flags; a sleep in the expiring cycle cancels that expiry
   always @(posedge aclk) begin
      if (!aresetn) begin
         timeout_status_flag   <= `FLAG_RESET;
         powerdown_status_flag <= `FLAG_RESET;
      end else if (sleep_instr && !sleeping_q) begin
         timeout_status_flag   <= 1'b1; // [R09]
         powerdown_status_flag <= 1'b0; // [R09]
      end else if (expire) begin
         timeout_status_flag <= 1'b0; // [R04]
      end
   end

   // Configuration word is a fuse: loaded by reset, never written
   always @(posedge aclk) begin
      if (!aresetn) begin
         config_q <= CONFIG_WORD;
      end else begin
         config_q <= config_q;
      end
   end

   // Write address and data may arrive in either order
   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_sel   = reg_decode(aw_idx_q);
   assign wr_lane0 = do_write && wstrb_q[0];
   assign wr_resp  = (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY; // Unmapped: error, no effect

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_idx_q      <= 14'h0000;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            aw_idx_q      <= s_axi_awaddr[15:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_resp;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Option register; only lane 0 carries data, other lanes are dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_option_control_q <= `OPTION_RESET;
      end else if (wr_lane0 && wr_sel == `SEL_OPTION) begin
         timer_option_control_q <= wdata_q[7:0]; // [R06]
      end
   end

   // Interrupt mask
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= 2'h0;
      end else if (wr_lane0 && wr_sel == `SEL_IRQ_MASK) begin
         irq_mask_q <= wdata_q[1:0];
      end
   end

   // Sticky interrupt status; a set in the clearing cycle survives
   assign irq_clr    = (wr_lane0 && wr_sel == `SEL_IRQ_STAT) ? wdata_q[1:0] : 2'h0;
   assign irq_set    = {expire_wake, expire_reset};
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 2'h0;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_d & irq_mask_q);
      end
   end

   // Status word as software reads it; bit 3 shows the fuse
   assign status_word = {28'h0000000, watchdog_enable_fuse, sleeping_q,
                         timeout_status_flag, powerdown_status_flag};

   // Read channel: one read under way at a time
   assign rd_sel = reg_decode(s_axi_araddr[15:2]);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RESP_OKAY;
         case (rd_sel)
            `SEL_STATUS: begin
               s_axi_rdata <= status_word;
            end
            `SEL_IRQ_STAT: begin
               s_axi_rdata <= {30'h00000000, irq_stat_q};
            end
            `SEL_IRQ_MASK: begin
               s_axi_rdata <= {30'h00000000, irq_mask_q};
            end
            `SEL_OPTION: begin
               s_axi_rdata <= {24'h000000, timer_option_control_q};
            end
            `SEL_CONFIG: begin
               s_axi_rdata <= {18'h00000, config_q};
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // wdt_top

`default_nettype wire

// file: bench/wdt_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the core-side handshake and flags of the watchdog
module wdt_monitor #(
   parameter [13:0] CONFIG_WORD = 14'h3fff
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic watchdog_clear_instr,
   input wire logic sleep_instr,
   input wire logic reset_req_q,
   input wire logic wake_req_q,
   input wire logic sleeping_q,
   input wire logic main_osc_en_q,
   input wire logic timeout_status_flag,
   input wire logic powerdown_status_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Expiry outcome depends on whether the core was asleep
   chk_reset_to_low: assert property (reset_req_q |-> !timeout_status_flag && !sleeping_q)
      else $error("reset request without time-out flag low");
   chk_reset_awake: assert property (reset_req_q |-> !$past(sleeping_q))
      else $error("reset request while asleep");
   chk_wake_resume: assert property (wake_req_q |-> !timeout_status_flag && !sleeping_q && main_osc_en_q)
      else $error("wake request without resume");
   chk_wake_asleep: assert property (wake_req_q |-> $past(sleeping_q))
      else $error("wake request while running");
   chk_sleep_flags: assert property (sleep_instr && !sleeping_q |=>
      sleeping_q && !main_osc_en_q && timeout_status_flag && !powerdown_status_flag)
      else $error("sleep entry flags wrong");
   chk_osc_halted: assert property (sleeping_q |-> !main_osc_en_q)
      else $error("main oscillator runs during sleep");
   // A fresh count needs far more than eight cycles to expire
   chk_clear_holds: assert property ((watchdog_clear_instr || sleep_instr) |=>
      (!reset_req_q && !wake_req_q) [*8])
      else $error("expiry soon after clear");
   chk_pulse_single: assert property (reset_req_q || wake_req_q |=> !reset_req_q && !wake_req_q)
      else $error("request pulse longer than one cycle");
   chk_fuse_off: assert property (!CONFIG_WORD[2] |-> !reset_req_q && !wake_req_q)
      else $error("expiry with enable fuse clear");

   cov_reset: cover property (reset_req_q);
   cov_wake: cover property (wake_req_q);
   cov_sleep: cover property (sleep_instr && !sleeping_q);
endmodule // wdt_monitor

bind wdt_top wdt_monitor #(.CONFIG_WORD(CONFIG_WORD)) wdt_monitor_inst (
   .aclk(aclk), .aresetn(aresetn), .watchdog_clear_instr(watchdog_clear_instr),
   .sleep_instr(sleep_instr), .reset_req_q(reset_req_q), .wake_req_q(wake_req_q),
   .sleeping_q(sleeping_q), .main_osc_en_q(main_osc_en_q),
   .timeout_status_flag(timeout_status_flag), .powerdown_status_flag(powerdown_status_flag));

`default_nettype wire

// file: bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Processor core as seen by the watchdog: one-cycle instruction pulses
module core_model (
   input  wire logic aclk,
   input  wire logic sleeping_q,
   output var  logic watchdog_clear_instr,
   output var  logic sleep_instr
);
   initial watchdog_clear_instr = 1'b0;
   initial sleep_instr = 1'b0;

   // A halted core executes nothing, so requests while asleep are dropped
   task automatic pulse(input bit slp);
      @(posedge aclk);
      if (sleeping_q !== 1'b1) begin
         if (slp) sleep_instr <= 1'b1;
         else watchdog_clear_instr <= 1'b1;
      end
      @(posedge aclk);
      sleep_instr <= 1'b0;
      watchdog_clear_instr <= 1'b0;
   endtask
endmodule // core_model

`default_nettype wire

// file: bench/watchdog_with_sleep_wakeup_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"

module watchdog_with_sleep_wakeup_tb;
   localparam logic [15:0] A_ST = {`IDX_STATUS, 2'h0};
   localparam logic [15:0] A_IS = {`IDX_IRQ_STAT, 2'h0};
   localparam logic [15:0] A_IM = {`IDX_IRQ_MASK, 2'h0};
   localparam logic [15:0] A_OP = {`IDX_OPTION, 2'h0};
   localparam logic [15:0] A_CF = {`IDX_CONFIG, 2'h0};
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [15:0] s_axi_awaddr = 16'h0;
   logic [15:0] s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'h0;
   logic        s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        watchdog_clear_instr, sleep_instr, reset_req_q, wake_req_q, sleeping_q;
   logic        main_osc_en_q, timeout_status_flag, powerdown_status_flag, irq_q;
   logic        fo_reset, fo_wake, fo_sleeping, fo_to;
   logic [31:0] fo_rdata;
   int          fo_pulses = 0;
   int          errors = 0;
   int          n_tests = 0;
   int          n;
   logic [1:0]  r;
   logic [31:0] d;

   // Tick every cycle keeps a base period of 256 cycles
   wdt_top #(.OSC_DIV(1)) wdt_top_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
      .reset_req_q(reset_req_q), .wake_req_q(wake_req_q), .sleeping_q(sleeping_q),
      .main_osc_en_q(main_osc_en_q), .timeout_status_flag(timeout_status_flag),
      .powerdown_status_flag(powerdown_status_flag), .irq_q(irq_q));

   core_model core_model_inst (.aclk(aclk), .sleeping_q(sleeping_q),
      .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr));

   // Same stimulus with the enable fuse clear; its bus timing matches the first
   wdt_top #(.OSC_DIV(1), .CONFIG_WORD(14'h3ffb)) fuse_off_wdt_top_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(), .s_axi_rdata(fo_rdata), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready(s_axi_rready), .watchdog_clear_instr(watchdog_clear_instr),
      .sleep_instr(sleep_instr), .reset_req_q(fo_reset), .wake_req_q(fo_wake),
      .sleeping_q(fo_sleeping), .main_osc_en_q(), .timeout_status_flag(fo_to),
      .powerdown_status_flag(), .irq_q());

   // Any request from the fuse-off instance is counted
   always @(posedge aclk) if (fo_reset === 1'b1 || fo_wake === 1'b1) fo_pulses <= fo_pulses + 1;

   // Clock
   always #5 aclk = ~aclk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Write: each channel dropped at its own handshake edge
   task automatic axw(input logic [15:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [15:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
      axr(a, d, r);
      check(what, d, exp);
      check("rresp", r, 2'h0);
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      axw(a, v, r);
      check("bresp", r, 2'h0);
   endtask

   // Edges until the chosen request pulse is sampled, capped at lim
   task automatic wait_evt(input bit wake, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge aclk);
         cnt++;
      end while (((wake ? wake_req_q : reset_req_q) !== 1'b1) && cnt < lim);
   endtask

   task automatic t_regs;
      rd(A_ST, 32'hb, "status");
      rd(A_OP, 32'hff, "option");
      rd(A_IM, 32'h0, "mask");
      rd(A_CF, 32'h3fff, "config");
      check("config off", fo_rdata, 32'h3ffb);
      s_axi_wstrb <= 4'he;
      wr(A_OP, 32'h0);
      s_axi_wstrb <= 4'hf;
      rd(A_OP, 32'hff, "option lane off");
      axr(16'h0100, d, r);
      check("unmapped rresp", r, 2'h2);
      axw(16'h0100, 32'h1, r);
      check("unmapped bresp", r, 2'h2);
      $display("test regs done");
   endtask

   task automatic t_run_expire;
      wr(A_IM, 32'h1);
      wr(A_OP, 32'h0);
      core_model_inst.pulse(1'b0);
      wait_evt(1'b0, 400, n);
      check("base period", n >= 250 && n <= 265, 1'b1);
      check("to flag", timeout_status_flag, 1'b0);
      rd(A_IS, 32'h1, "irq stat");
      check("irq", irq_q, 1'b1);
      wr(A_IS, 32'h1);
      rd(A_IS, 32'h0, "irq stat");
      check("irq", irq_q, 1'b0);
      $display("test run expire done");
   endtask

   task automatic t_sleep_wake;
      core_model_inst.pulse(1'b1);
      #1;
      check("sleeping", sleeping_q, 1'b1);
      check("main osc", main_osc_en_q, 1'b0);
      check("to flag", timeout_status_flag, 1'b1);
      check("pd flag", powerdown_status_flag, 1'b0);
      // Core clock is off here; only the watchdog's own tick can end sleep
      wait_evt(1'b1, 400, n);
      check("wake period", n >= 249 && n <= 265, 1'b1);
      check("to flag", timeout_status_flag, 1'b0);
      check("main osc", main_osc_en_q, 1'b1);
      check("fuse off asleep", fo_sleeping, 1'b1);
      check("fuse off to flag", fo_to, 1'b1);
      rd(A_ST, 32'h8, "status");
      rd(A_IS, 32'h2, "irq stat");
      check("masked irq", irq_q, 1'b0);
      wr(A_IM, 32'h3);
      // Interrupt output follows the mask one cycle after the write lands
      @(posedge aclk);
      check("irq", irq_q, 1'b1);
      wr(A_IS, 32'h2);
      rd(A_IS, 32'h0, "irq stat");
      check("irq", irq_q, 1'b0);
      $display("test sleep wake done");
   endtask

   task automatic t_postscale;
      wr(A_OP, 32'h9);
      core_model_inst.pulse(1'b0);
      wait_evt(1'b0, 300, n);
      check("no early expiry", n, 300);
      core_model_inst.pulse(1'b0);
      wait_evt(1'b0, 600, n);
      check("postscaled period", n >= 505 && n <= 525, 1'b1);
      rd(A_OP, 32'h9, "option kept");
      check("fuse off pulses", fo_pulses, 0);
      $display("test postscale done");
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Whole run is about 1500 cycles; this allows twenty times that
   initial begin
      #300000;
      errors++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_run_expire();
      t_sleep_wake();
      t_postscale();
      conclude();
   end
endmodule // watchdog_with_sleep_wakeup_tb

`default_nettype wire
